// >>> egf_follower.sv
`timescale 1ns/100ps

// Contract
// - Position reference is increments times gear ratio
// - Accept A/B, P/D or CW/CCW reference
// - Exactly three follow methods by configuration
// - No compensation: drop increments while interrupted
// - Compensation: hold increments, make up afterwards
// - Velocity sync: follow rate, not position
// - Motor resolution 131072 increments per revolution
// - Following starts when power stage enables
// - Disabling power stage ends gear mode
// - Enable input drives power stage; reset clears
// - Ratio-select input switches two ratios live
// - Gear factor is numerator over denominator
// - Selector picks fixed ratio or pair
// - Negative numerator reverses motor direction
// - No-fault in states 4-6; active in 6
// - Option inverts reference signals before decoding
// - Fault-clear input clears reported error
// - Selector 0 pair; 1-11 fixed per-rev
// - Ratio takes effect when numerator written
module egf_follower #(
    parameter int POS_W = 32,
    parameter int VEL_WINDOW = egf_pkg::VEL_WINDOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Reference pulse pins
    input wire logic pulse_train_input_a,
    input wire logic pulse_train_input_b,
    // Configuration
    input wire egf_pkg::egf_pulse_t cfg_pulse_type,
    input wire logic cfg_invert,
    input wire egf_pkg::egf_method_t cfg_method,
    input wire logic [3:0] ratio_selector,
    input wire egf_pkg::egf_ratio_t ratio_first,
    input wire logic ratio_first_num_wr,
    input wire egf_pkg::egf_ratio_t ratio_second,
    input wire logic ratio_second_num_wr,
    // Digital input pins
    input wire logic input_zero_enable,
    input wire logic input_one_fault_clear,
    input wire logic input_four_ratio_select,
    input wire logic input_five_halt,
    // Class 1 error event from drive monitoring
    input wire logic error_class_one,
    // Digital outputs
    output logic output_zero_no_fault,
    output logic output_one_active,
    output logic output_three_standstill,
    output logic output_four_selected_error,
    // Drive side
    output logic power_stage_on,
    output logic [POS_W-1:0] position_reference,
    output logic signed [31:0] motor_velocity,
    output egf_pkg::egf_state_t op_state
);

    // Elaboration check: the window counter is 16 bits and the step arithmetic assumes these widths
    if (POS_W < 16 || POS_W > 64 || VEL_WINDOW < 1 || VEL_WINDOW > 65535) begin : g_bad_param
        $error("egf_follower: unsupported parameter value");
    end

    // Two-flop synchronisers for all pins; stage one is read only by stage two
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
        end else begin
            pin_s1 <= {input_five_halt, input_four_ratio_select, input_one_fault_clear,
                       input_zero_enable, pulse_train_input_b, pulse_train_input_a};
            pin_s2 <= pin_s1;
        end
    end

    wire sig_a = pin_s2[0] ^ cfg_invert;
    wire sig_b = pin_s2[1] ^ cfg_invert;
    wire en_s = pin_s2[2];
    wire clr_s = pin_s2[3];
    wire sel2_s = pin_s2[4];
    wire halt_s = pin_s2[5];

    // Previous decoded levels for edge detection
    logic prev_a;
    logic prev_b;
    logic prev_clr;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            prev_clr <= 1'b0;
        end else begin
            prev_a <= sig_a;
            prev_b <= sig_b;
            prev_clr <= clr_s;
        end
    end

    // Decoder: quadrature counts every edge, a simultaneous A and B change is illegal and dropped
    wire a_chg = sig_a ^ prev_a;
    wire b_chg = sig_b ^ prev_b;
    wire a_rise = sig_a & ~prev_a;
    wire b_rise = sig_b & ~prev_b;
    wire quad_step = a_chg ^ b_chg;
    wire quad_up = sig_a ^ prev_b;
    wire dec_step = (cfg_pulse_type == egf_pkg::EGF_PULSE_AB) ? quad_step :
                    (cfg_pulse_type == egf_pkg::EGF_PULSE_PD) ? a_rise :
                    (cfg_pulse_type == egf_pkg::EGF_PULSE_CW_CCW) ? (a_rise ^ b_rise) : 1'b0;
    wire dec_up = (cfg_pulse_type == egf_pkg::EGF_PULSE_AB) ? quad_up :
                  (cfg_pulse_type == egf_pkg::EGF_PULSE_PD) ? sig_b : a_rise;

    // Operating state machine
    egf_pkg::egf_state_t state;
    egf_pkg::egf_state_t next_state;
    logic err_pend;
    always_comb begin
        next_state = state;
        case (state)
            egf_pkg::EGF_ST_SWITCH_ON_DISABLED: next_state = egf_pkg::EGF_ST_READY;
            egf_pkg::EGF_ST_READY: begin
                if (en_s) next_state = egf_pkg::EGF_ST_SWITCHED_ON;
            end
            egf_pkg::EGF_ST_SWITCHED_ON: begin
                next_state = en_s ? egf_pkg::EGF_ST_OP_ENABLED : egf_pkg::EGF_ST_READY;
            end
            egf_pkg::EGF_ST_OP_ENABLED: begin
                if (!en_s) next_state = egf_pkg::EGF_ST_READY;
                else if (err_pend) next_state = egf_pkg::EGF_ST_QUICK_STOP;
            end
            egf_pkg::EGF_ST_QUICK_STOP: begin
                if (!en_s) next_state = egf_pkg::EGF_ST_SWITCH_ON_DISABLED;
                else if (!err_pend) next_state = egf_pkg::EGF_ST_OP_ENABLED;
            end
            default: next_state = egf_pkg::EGF_ST_SWITCH_ON_DISABLED;
        endcase
    end

    // Error flag: a new error in the clearing cycle wins over the clear
    wire clr_edge = clr_s & ~prev_clr;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= egf_pkg::EGF_ST_SWITCH_ON_DISABLED;
            err_pend <= 1'b0;
        end else begin
            state <= next_state;
            err_pend <= error_class_one | (err_pend & ~clr_edge);
        end
    end

    wire mode_on = (state == egf_pkg::EGF_ST_OP_ENABLED) || (state == egf_pkg::EGF_ST_QUICK_STOP);
    wire interrupted = halt_s || (state == egf_pkg::EGF_ST_QUICK_STOP);
    wire is_comp = (cfg_method == egf_pkg::EGF_POS_COMP);
    wire is_vel = (cfg_method == egf_pkg::EGF_VEL_SYNC);

    // Active ratio pairs; each pair is taken together when its numerator is written
    egf_pkg::egf_ratio_t pair_one;
    egf_pkg::egf_ratio_t pair_two;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pair_one <= {egf_pkg::RATIO_NUM_RESET, egf_pkg::RATIO_DEN_RESET};
            pair_two <= {egf_pkg::RATIO_NUM_RESET, egf_pkg::RATIO_DEN_RESET};
        end else begin
            if (ratio_first_num_wr) pair_one <= ratio_first;
            if (ratio_second_num_wr) pair_two <= ratio_second;
        end
    end

    // Ratio selection; a selector beyond the table falls back to the pair
    wire use_pair = (ratio_selector == egf_pkg::RATIO_SEL_PAIR) ||
                    (ratio_selector > egf_pkg::RATIO_SEL_MAX);
    wire egf_pkg::egf_ratio_t pair_live = sel2_s ? pair_two : pair_one;
    wire logic signed [31:0] num_eff = use_pair ? pair_live.num : $signed(egf_pkg::MOTOR_INC_PER_REV);
    wire logic [31:0] den_eff = use_pair ? pair_live.den : egf_pkg::egf_fixed_den(ratio_selector);
    wire logic [31:0] den_safe = (den_eff == 32'h0) ? 32'h1 : den_eff;

    // Pending reference increments waiting for scaling
    logic signed [15:0] pending;
    logic [31:0] rem;
    logic busy;
    wire accept = mode_on && (!interrupted || is_comp);
    wire logic signed [15:0] step_val = !(accept && dec_step) ? 16'sh0000 : (dec_up ? 16'sh0001 : 16'shffff);
    wire start = mode_on && !busy && !interrupted && (pending != 16'sh0000);
    wire logic signed [15:0] next_pending = (start ? 16'sh0000 : pending) + step_val;

    // Scaled dividend: carried remainder plus pending times numerator
    wire logic [31:0] rem_use = (rem < den_safe) ? rem : 32'h0;
    wire logic signed [47:0] prod = pending * num_eff;
    wire logic signed [49:0] div_in = {{2{prod[47]}}, prod} + {18'h0, rem_use};
    wire logic [49:0] div_mag = div_in[49] ? (50'h0 - div_in) : div_in;

    // Restoring divider, one quotient bit per cycle
    logic [49:0] dq;
    logic [31:0] dr;
    logic [31:0] dden;
    logic dneg;
    logic [5:0] dcnt;
    wire logic [32:0] dr_sh = {dr, dq[49]};
    wire ge = dr_sh >= {1'b0, dden};
    wire logic [32:0] dr_sub = dr_sh - {1'b0, dden};
    wire logic [31:0] dr_next = ge ? dr_sub[31:0] : dr_sh[31:0];
    wire logic [49:0] dq_next = {dq[48:0], ge};
    wire done = busy && (dcnt == egf_pkg::DIV_LAST);

    // Floor division so the remainder always stays in [0, den)
    wire exact = (dr_next == 32'h0);
    wire logic signed [49:0] q_fin = !dneg ? $signed(dq_next) :
                                     exact ? -$signed(dq_next) : -$signed(dq_next) - 50'sd1;
    wire logic [31:0] r_fin = (!dneg || exact) ? dr_next : (dden - dr_next);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= 16'sh0000;
            busy <= 1'b0;
            dcnt <= 6'h00;
            dq <= 50'h0;
            dr <= 32'h0;
            dden <= 32'h1;
            dneg <= 1'b0;
        end else if (!mode_on) begin
            // Leaving the gear mode drops all scaling work
            pending <= 16'sh0000;
            busy <= 1'b0;
            dcnt <= 6'h00;
        end else begin
            pending <= next_pending;
            if (start) begin
                busy <= 1'b1;
                dcnt <= 6'h00;
                dq <= div_mag;
                dr <= 32'h0;
                dden <= den_safe;
                dneg <= div_in[49];
            end else if (busy) begin
                dq <= dq_next;
                dr <= dr_next;
                dcnt <= dcnt + 6'h01;
                if (done) busy <= 1'b0;
            end
        end
    end

    // Position reference and remainder; velocity mode does not move the position
    logic signed [31:0] vel_sum;
    logic [15:0] win_cnt;
    wire win_end = (win_cnt == 16'(VEL_WINDOW - 1));
    wire logic signed [31:0] q_short = q_fin[31:0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem <= 32'h0;
            position_reference <= '0;
        end else if (!mode_on) begin
            rem <= 32'h0;
        end else if (done) begin
            rem <= r_fin;
            if (!is_vel) position_reference <= position_reference + POS_W'(q_fin);
        end
    end

    // Velocity in motor increments per window; tracks rate only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vel_sum <= 32'sh0;
            win_cnt <= 16'h0;
            motor_velocity <= 32'sh0;
        end else begin
            win_cnt <= win_end ? 16'h0 : win_cnt + 16'h1;
            if (win_end) begin
                motor_velocity <= mode_on ? (vel_sum + (done ? q_short : 32'sh0)) : 32'sh0;
                vel_sum <= 32'sh0;
            end else if (done) begin
                vel_sum <= vel_sum + q_short;
            end
        end
    end

    // Status outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_zero_no_fault <= 1'b0;
            output_one_active <= 1'b0;
            output_three_standstill <= 1'b1;
            output_four_selected_error <= 1'b0;
            power_stage_on <= 1'b0;
            op_state <= egf_pkg::EGF_ST_SWITCH_ON_DISABLED;
        end else begin
            output_zero_no_fault <= (next_state == egf_pkg::EGF_ST_READY) ||
                                    (next_state == egf_pkg::EGF_ST_SWITCHED_ON) ||
                                    (next_state == egf_pkg::EGF_ST_OP_ENABLED);
            output_one_active <= (next_state == egf_pkg::EGF_ST_OP_ENABLED);
            output_three_standstill <= (motor_velocity == 32'sh0) && !busy;
            output_four_selected_error <= err_pend;
            power_stage_on <= (next_state == egf_pkg::EGF_ST_OP_ENABLED) ||
                              (next_state == egf_pkg::EGF_ST_QUICK_STOP);
            op_state <= next_state;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_active_with_state: assert property (output_one_active == (op_state == egf_pkg::EGF_ST_OP_ENABLED))
        else $error("active output disagrees with state");
    a_no_fault_states: assert property (output_zero_no_fault |-> (op_state != egf_pkg::EGF_ST_QUICK_STOP)
        && (op_state != egf_pkg::EGF_ST_SWITCH_ON_DISABLED))
        else $error("no-fault output outside states 4 to 6");
    a_disable_ends_mode: assert property (!en_s && mode_on |=> !power_stage_on && !output_one_active)
        else $error("power stage stayed on after enable dropped");
    a_enable_starts: assert property ($rose(en_s) && state == egf_pkg::EGF_ST_READY && !err_pend
        |-> ##2 power_stage_on)
        else $error("gear mode did not start after enable");
    a_fault_clear_works: assert property (clr_edge && !error_class_one |=> !err_pend)
        else $error("fault clear did not clear the error");
    a_drop_no_comp: assert property (mode_on && interrupted && !is_comp |=> $stable(pending))
        else $error("increments kept while interrupted without compensation");
    a_hold_comp: assert property (mode_on && interrupted && is_comp && dec_step && !busy
        && pending != 16'sh7fff && pending != -16'sh7fff |=> pending != $past(pending))
        else $error("increment lost during interruption with compensation");
    a_divide_bounded: assert property (start |=> busy ##[49:50] !busy)
        else $error("scaling did not finish in bounded time");
    a_remainder_range: assert property (done |-> r_fin < dden)
        else $error("remainder out of range");
    a_ratio_latched: assert property (ratio_first_num_wr |=> pair_one == $past(ratio_first))
        else $error("ratio pair not taken on numerator write");

endmodule

// >>> egf_pkg.sv
package egf_pkg;

    // Clock and derived timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int VEL_WINDOW_NS = 10000;
    localparam int VEL_WINDOW_CYC = VEL_WINDOW_NS / CLK_PERIOD_NS;

    // Motor resolution in increments per revolution
    localparam logic [31:0] MOTOR_INC_PER_REV = 32'h0002_0000;

    // Ratio pair reset values (numerator and denominator)
    localparam logic signed [31:0] RATIO_NUM_RESET = 32'sh0000_0001;
    localparam logic [31:0] RATIO_DEN_RESET = 32'h0000_0001;

    // Selector value that picks the numerator/denominator pair
    localparam logic [3:0] RATIO_SEL_PAIR = 4'h0;
    localparam logic [3:0] RATIO_SEL_MAX = 4'hb;

    // Divider length: bits of the scaled dividend
    localparam int DIV_BITS = 50;
    localparam logic [5:0] DIV_LAST = 6'h31;

    // Reference signal type
    typedef enum logic [1:0] {
        EGF_PULSE_AB = 2'h0,
        EGF_PULSE_PD = 2'h1,
        EGF_PULSE_CW_CCW = 2'h2
    } egf_pulse_t;

    // Follow method
    typedef enum logic [1:0] {
        EGF_POS_NO_COMP = 2'h0,
        EGF_POS_COMP = 2'h1,
        EGF_VEL_SYNC = 2'h2
    } egf_method_t;

    // Operating states, one-hot
    typedef enum logic [4:0] {
        EGF_ST_SWITCH_ON_DISABLED = 5'h01,
        EGF_ST_READY = 5'h02,
        EGF_ST_SWITCHED_ON = 5'h04,
        EGF_ST_OP_ENABLED = 5'h08,
        EGF_ST_QUICK_STOP = 5'h10
    } egf_state_t;

    // Configurable gear ratio pair
    typedef struct packed {
        logic signed [31:0] num;
        logic [31:0] den;
    } egf_ratio_t;

    // Reference increments per motor revolution for the fixed ratios
    function automatic logic [31:0] egf_fixed_den(input logic [3:0] sel);
        logic [31:0] d;
        d = 32'h0000_0001;
        case (sel)
            4'h1: d = 32'h0000_00c8;
            4'h2: d = 32'h0000_0190;
            4'h3: d = 32'h0000_01f4;
            4'h4: d = 32'h0000_03e8;
            4'h5: d = 32'h0000_07d0;
            4'h6: d = 32'h0000_0fa0;
            4'h7: d = 32'h0000_1388;
            4'h8: d = 32'h0000_2710;
            4'h9: d = 32'h0000_1000;
            4'ha: d = 32'h0000_2000;
            4'hb: d = 32'h0000_4000;
            default: d = 32'h0000_0001;
        endcase
        return d;
    endfunction

endpackage

// >>> egf_pulse_src.sv
`timescale 1ns/100ps

// Controller model: push-pull pins that always hold a level, so no idle pattern is needed
module egf_pulse_src (
    // Clock
    input wire logic clk,
    // Reference pins
    output logic pin_a,
    output logic pin_b
);
    logic a = 1'b0;
    logic b = 1'b0;
    logic inv = 1'b0;
    logic [1:0] ph = 2'h0;

    // Optional inversion on the wire
    assign pin_a = a ^ inv;
    assign pin_b = b ^ inv;

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One increment; quadrature has A leading for up
    task automatic step(input logic [1:0] kind, input logic up);
        if (kind == egf_pkg::EGF_PULSE_AB) begin
            ph = up ? ph + 2'h1 : ph - 2'h1;
            a = ph[1] ^ ph[0];
            b = ph[1];
            hold(2);
        end else if (kind == egf_pkg::EGF_PULSE_PD) begin
            b = up;
            hold(2);
            a = 1'b1;
            hold(2);
            a = 1'b0;
            hold(2);
        end else begin
            if (up) a = 1'b1;
            else b = 1'b1;
            hold(2);
            a = 1'b0;
            b = 1'b0;
            hold(2);
        end
    endtask

    task automatic send(input logic [1:0] kind, input int n, input logic up);
        repeat (n) step(kind, up);
    endtask
endmodule

// >>> electronic_gear_follower_tb.sv
`timescale 1ns/100ps

module electronic_gear_follower_tb;
    typedef struct packed {
        logic [1:0] kind;
        logic [31:0] v;
    } egf_note_t;
    localparam int VEL_WIN = 10;
    localparam logic [8:0] OUT_RDY = {4'h8, 5'h02};
    localparam logic [8:0] OUT_RUN = {4'he, 5'h08};
    localparam logic [8:0] OUT_QS = {4'h3, 5'h10};
    localparam int FIX_DEN [11] = '{16'h00c8, 16'h0190, 16'h01f4, 16'h03e8, 16'h07d0, 16'h0fa0,
        16'h1388, 16'h2710, 16'h1000, 16'h2000, 16'h4000};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pin_a, pin_b, cfg_invert, ratio_first_num_wr, ratio_second_num_wr;
    logic input_zero_enable, input_one_fault_clear, input_four_ratio_select, input_five_halt;
    logic error_class_one, no_fault, active, standstill, sel_err, power_on;
    logic [3:0] ratio_selector;
    logic [31:0] pos;
    logic signed [31:0] vel;
    egf_pkg::egf_pulse_t cfg_pulse_type;
    egf_pkg::egf_method_t cfg_method;
    egf_pkg::egf_ratio_t ratio_first, ratio_second;
    egf_pkg::egf_state_t st;
    egf_note_t q[$];
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    longint base = 0, seg_n = 0, cur_num = 1, cur_den = 1, vel_acc = 0;
    event go;

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    egf_pulse_src src (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

    // Short velocity window keeps the run brief
    egf_follower #(.POS_W(32), .VEL_WINDOW(VEL_WIN)) DUT (.clk(clk), .rst(rst), .pulse_train_input_a(pin_a),
        .pulse_train_input_b(pin_b), .cfg_pulse_type(cfg_pulse_type), .cfg_invert(cfg_invert),
        .cfg_method(cfg_method), .ratio_selector(ratio_selector), .ratio_first(ratio_first),
        .ratio_first_num_wr(ratio_first_num_wr), .ratio_second(ratio_second),
        .ratio_second_num_wr(ratio_second_num_wr), .input_zero_enable(input_zero_enable),
        .input_one_fault_clear(input_one_fault_clear), .input_four_ratio_select(input_four_ratio_select),
        .input_five_halt(input_five_halt), .error_class_one(error_class_one), .output_zero_no_fault(no_fault),
        .output_one_active(active), .output_three_standstill(standstill), .output_four_selected_error(sel_err),
        .power_stage_on(power_on), .position_reference(pos), .motor_velocity(vel), .op_state(st));

    function automatic longint fdiv(input longint x, input longint d);
        longint r;
        r = x / d;
        if ((x % d != 0) && (x < 0)) r = r - 1;
        return r;
    endfunction

    function automatic int odd_part(input int d);
        while (d % 2 == 0) d = d / 2;
        return d;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmp_pos(input logic [31:0] e);
        tests_run++;
        if (pos !== e) begin
            fail_count++;
            $display("ERROR %0t position %h expected %h", $time, pos, e);
        end
    endtask

    task automatic cmp_out(input logic [8:0] e);
        tests_run++;
        if ({no_fault, active, power_on, sel_err, st} !== e) begin
            fail_count++;
            $display("ERROR %0t status %h expected %h", $time, {no_fault, active, power_on, sel_err, st}, e);
        end
    endtask

    task automatic cmp_vel(input logic [31:0] e);
        tests_run++;
        if (vel_acc !== e) begin
            fail_count++;
            $display("ERROR %0t velocity sum %0d expected %0d", $time, vel_acc, e);
        end
    endtask

    task automatic note_pos();
        longint e;
        e = base + fdiv(seg_n * cur_num, cur_den);
        q.push_back('{2'h0, e[31:0]});
    endtask

    task automatic note_out(input logic [8:0] o);
        q.push_back('{2'h1, {23'h0, o}});
    endtask

    task automatic note_vel(input longint v);
        q.push_back('{2'h2, v[31:0]});
    endtask

    // Wait for motion to end, then release the notes to the checker
    // Standstill must hold longer than a window: it blinks high for a cycle between two batches
    task automatic settle();
        int i;
        int run;
        i = 0;
        run = 0;
        while (run < VEL_WIN + 2 && i < 600) begin
            cyc(1);
            run = (standstill === 1'b1) ? run + 1 : 0;
            i++;
        end
        if (run < VEL_WIN + 2) begin
            fail_count++;
            $display("ERROR %0t no standstill", $time);
        end
        cyc(2);
        -> go;
        cyc(1); // Let the checker drain the queue before new notes arrive
    endtask

    task automatic inc(input int n, input logic up, input logic counted);
        src.send(cfg_pulse_type, n, up);
        if (counted) seg_n += up ? n : -n;
        cyc(4);
    endtask

    // A remainder below the new denominator carries into the next ratio, so start each ratio from a whole step
    task automatic new_seg(input longint num, input longint den);
        if (((seg_n * cur_num) % cur_den) != 0) inc(1, 1'b1, 1'b1);
        base = base + fdiv(seg_n * cur_num, cur_den);
        seg_n = 0;
        cur_num = num;
        cur_den = den;
    endtask

    task automatic set_ratio(input logic second, input logic signed [31:0] n, input logic [31:0] d);
        if (second) ratio_second.den = d;
        else ratio_first.den = d;
        cyc(1);
        ratio_second.num = second ? n : ratio_second.num;
        ratio_first.num = second ? ratio_first.num : n;
        ratio_second_num_wr = second;
        ratio_first_num_wr = ~second;
        cyc(1);
        ratio_second_num_wr = 1'b0;
        ratio_first_num_wr = 1'b0;
    endtask

    // Halt around an inversion change: the option acts at once, the pins only after the synchroniser
    task automatic set_inv(input logic v);
        input_five_halt = 1'b1;
        cyc(4);
        cfg_invert = v;
        src.inv = v;
        cyc(4);
        input_five_halt = 1'b0;
        cyc(4);
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Checker side: oldest note against the settled outputs
    initial begin
        egf_note_t n;
        forever begin
            @(go);
            while (q.size() > 0) begin
                n = q.pop_front();
                if (n.kind == 2'h1) cmp_out(n.v[8:0]);
                else if (n.kind == 2'h2) cmp_vel(n.v);
                else cmp_pos(n.v);
            end
        end
    end

    // Each velocity value stands one window, so the per-cycle sum is window length times motion
    always @(posedge clk) vel_acc += vel;

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            $display("ERROR %0t run did not finish", $time);
            tally_and_finish();
        end
    end

    // Driver
    initial begin
        {cfg_invert, ratio_first_num_wr, ratio_second_num_wr, input_zero_enable} = 4'h0;
        {input_one_fault_clear, input_four_ratio_select, input_five_halt, error_class_one} = 4'h0;
        ratio_first = '{32'sh1, 32'h1};
        ratio_second = '{32'sh1, 32'h1};
        ratio_selector = 4'h0;
        cfg_pulse_type = egf_pkg::EGF_PULSE_CW_CCW;
        cfg_method = egf_pkg::EGF_POS_NO_COMP;
        void'($urandom(94));
        cyc(20);
        rst = 1'b0;
        note_out(OUT_RDY);
        settle();
        input_zero_enable = 1'b1;
        note_out(OUT_RUN);
        settle();
        for (int t = 2; t >= 0; t--) begin
            cfg_pulse_type = egf_pkg::egf_pulse_t'(t);
            cyc(4);
            inc((t == 0 ? 4 : 1) * $urandom_range(12, 1), 1'b1, 1'b1);
            inc(t == 0 ? 4 : 3, 1'b0, 1'b1);
            note_pos();
            settle();
        end
        cfg_pulse_type = egf_pkg::EGF_PULSE_PD;
        new_seg(3, 2);
        set_ratio(1'b0, 32'sh3, 32'h2);
        repeat (2) begin
            inc($urandom_range(9, 1), 1'b1, 1'b1);
            note_pos();
            settle();
        end
        set_inv(1'b1);
        inc($urandom_range(9, 1), 1'b0, 1'b1);
        note_pos();
        settle();
        set_inv(1'b0);
        new_seg(-1, 1);
        set_ratio(1'b1, 32'shffff_ffff, 32'h1);
        input_four_ratio_select = 1'b1;
        cyc(4);
        inc($urandom_range(9, 1), 1'b1, 1'b1);
        note_pos();
        settle();
        input_four_ratio_select = 1'b0;
        for (int s = 1; s <= 11; s++) begin
            new_seg(egf_pkg::MOTOR_INC_PER_REV, FIX_DEN[s-1]);
            ratio_selector = 4'(s);
            cyc(4);
            inc(odd_part(FIX_DEN[s-1]) * $urandom_range(2, 1), 1'b1, 1'b1);
            note_pos();
            settle();
        end
        new_seg(3, 2);
        ratio_selector = 4'h0;
        cyc(4);
        input_five_halt = 1'b1;
        cyc(4);
        inc($urandom_range(9, 1), 1'b1, 1'b0);
        input_five_halt = 1'b0;
        note_pos();
        settle();
        cfg_method = egf_pkg::EGF_POS_COMP;
        input_five_halt = 1'b1;
        cyc(4);
        inc($urandom_range(9, 1), 1'b1, 1'b1);
        input_five_halt = 1'b0;
        note_pos();
        settle();
        error_class_one = 1'b1;
        cyc(1);
        error_class_one = 1'b0;
        cyc(4);
        note_out(OUT_QS);
        settle();
        inc($urandom_range(9, 1), 1'b1, 1'b1);
        input_one_fault_clear = 1'b1;
        cyc(4);
        input_one_fault_clear = 1'b0;
        note_out(OUT_RUN);
        note_pos();
        settle();
        new_seg(3, 2);
        settle();
        vel_acc = 0;
        cfg_method = egf_pkg::EGF_VEL_SYNC;
        cyc(2);
        inc(40, 1'b1, 1'b0);
        note_pos();
        note_vel(VEL_WIN * fdiv(40 * 3, 2));
        settle();
        input_zero_enable = 1'b0;
        cyc(4);
        inc($urandom_range(9, 1), 1'b1, 1'b0);
        note_out(OUT_RDY);
        note_pos();
        settle();
        cfg_method = egf_pkg::EGF_POS_NO_COMP;
        input_zero_enable = 1'b1;
        cyc(6);
        inc($urandom_range(9, 1), 1'b1, 1'b1);
        note_out(OUT_RUN);
        note_pos();
        settle();
        tally_and_finish();
    end
endmodule
